/* File: core/psm_phase_config_regs.sv */
// Wishbone register bank holding the power savings and phase configuration.
`timescale 1ns/1ps
`include "psm_cfg_regs.svh"
module psm_phase_config_regs
   import psm_cfg_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic POWER_GOOD_INPUT,
   input wire logic POWER_SAVINGS_INDICATOR,
   input wire logic PIN_PSM_TWO_PHASES,
   input wire logic PIN_NB_DROOP_ENABLE,
   input wire logic PWM_CYCLE_TICK,
   output logic [5:0] PHASE_ENABLE,
   output logic DIODE_EMULATION,
   output logic OFFSET_APPLIED,
   output logic [1:0] GATE_DRIVE_OPTIMISATION_LEVEL,
   output logic [1:0] DROOP_GAIN_SEL,
   output logic NB_DROOP_ENABLE,
   output logic [1:0] SLEW_RATE_SEL,
   output logic ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN,
   output logic ALIGNMENT_MONITOR_COMP
);
   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   // Power good, the power savings request and the straps come from pins,
   // so each is brought into the clock domain before any logic looks at it.
   logic pgood_s;
   logic psi_s;
   logic strap_two_s;
   logic strap_nb_s;

   level_sync u_sync_pgood (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .d(POWER_GOOD_INPUT),
      .q(pgood_s)
   );

   level_sync u_sync_psi (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .d(POWER_SAVINGS_INDICATOR),
      .q(psi_s)
   );

   level_sync u_sync_strap_two (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .d(PIN_PSM_TWO_PHASES),
      .q(strap_two_s)
   );

   level_sync u_sync_strap_nb (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .d(PIN_NB_DROOP_ENABLE),
      .q(strap_nb_s)
   );

   // ==========================================================================
   // Configuration registers
   // ==========================================================================
   logic [7:0] power_savings_control_reg;
   logic [7:0] phase_count_gate_level_reg;
   logic [7:0] droop_and_psm_phase_override_reg;
   logic [7:0] slew_and_alignment_control_reg;

   // ==========================================================================
   // Wishbone slave
   // ==========================================================================
   // Every access is answered one enabled cycle after the strobe is seen, so
   // while CE is high the master never waits more than one clock. Unmapped addresses read zero
   // and drop writes, but are still acknowledged to keep the bus alive.
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic req;
   logic wr_req;
   logic wr_ps;
   logic wr_pg;
   logic wr_dr;
   logic wr_sa;
   logic cfg_unlocked;
   logic [31:0] rdata_next;
   logic [31:0] status_word;

   assign req = CYC_I && STB_I && !ack_reg;
   assign wr_req = req && WE_I && SEL_I[0];
   // Phase, droop and slew writes are refused while power good is seen high; power-savings writes still land.
   assign cfg_unlocked = !pgood_s;
   assign wr_ps = wr_req && (ADR_I == `OFS_POWER_SAVINGS);
   assign wr_pg = wr_req && cfg_unlocked && (ADR_I == `OFS_PHASE_GATE);
   assign wr_dr = wr_req && cfg_unlocked && (ADR_I == `OFS_DROOP_OVERRIDE);
   assign wr_sa = wr_req && cfg_unlocked && (ADR_I == `OFS_SLEW_ALIGN);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ack_reg <= 1'b0;
      end else if (CE) begin
         ack_reg <= req;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         power_savings_control_reg <= `RST_POWER_SAVINGS;
      end else if (CE && wr_ps) begin
         // Reserved bits are never stored, so they read zero and act on nothing.
         power_savings_control_reg <= DAT_I[7:0] & `MASK_POWER_SAVINGS;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         phase_count_gate_level_reg <= `RST_PHASE_GATE;
      end else if (CE && wr_pg) begin
         phase_count_gate_level_reg <= DAT_I[7:0] & `MASK_PHASE_GATE;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         droop_and_psm_phase_override_reg <= `RST_DROOP_OVERRIDE;
      end else if (CE && wr_dr) begin
         droop_and_psm_phase_override_reg <= DAT_I[7:0] & `MASK_DROOP_OVERRIDE;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         slew_and_alignment_control_reg <= `RST_SLEW_ALIGN;
      end else if (CE && wr_sa) begin
         slew_and_alignment_control_reg <= DAT_I[7:0] & `MASK_SLEW_ALIGN;
      end
   end

   // ==========================================================================
   // Read path
   // ==========================================================================
   seq_if sif ();

   assign status_word = {24'h000000, sif.stepping, sif.cur_count, 1'b0,
                         strap_two_s, psi_s, pgood_s};

   always_comb begin
      rdata_next = 32'h00000000;
      case (ADR_I)
         `OFS_POWER_SAVINGS: rdata_next = {24'h000000, power_savings_control_reg};
         `OFS_PHASE_GATE: rdata_next = {24'h000000, phase_count_gate_level_reg};
         `OFS_DROOP_OVERRIDE: rdata_next = {24'h000000, droop_and_psm_phase_override_reg};
         `OFS_SLEW_ALIGN: rdata_next = {24'h000000, slew_and_alignment_control_reg};
         `OFS_STATUS: rdata_next = status_word;
         default: rdata_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata_reg <= 32'h00000000;
      end else if (CE) begin
         if (req && !WE_I) begin
            rdata_reg <= rdata_next;
         end else begin
            rdata_reg <= 32'h00000000;
         end
      end
   end

   assign ACK_O = ack_reg;
   assign DAT_O = rdata_reg;

   // ==========================================================================
   // Phase sequencing
   // ==========================================================================
   // The phase field is decoded as a thermometer; a field with a gap counts
   // only its unbroken low run, which keeps the count safe but is not defined.
   phase_count_t full_count;
   phase_count_t psm_count;
   logic [1:0] psm_override;

   assign full_count = therm_to_count(phase_count_gate_level_reg[`PG_PHASE_LSB +: 5]);
   assign psm_override = droop_and_psm_phase_override_reg[`DR_PSM_LSB +: 2];

   always_comb begin
      if (psm_override[1]) begin
         psm_count = psm_override[0] ? 3'd2 : 3'd1;
      end else begin
         psm_count = strap_two_s ? 3'd2 : 3'd1;
      end
   end

   assign sif.full_count = full_count;
   assign sif.psm_count = psm_count;
   assign sif.psm_active = psi_s;
   assign sif.add_gap = gap_t'(power_savings_control_reg[`PS_ADD_LSB +: 2]);
   assign sif.drop_gap = gap_t'(power_savings_control_reg[`PS_DROP_LSB +: 2]);
   assign sif.pwm_tick = PWM_CYCLE_TICK;

   phase_sequencer u_seq (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .sif(sif)
   );

   // ==========================================================================
   // Output decode
   // ==========================================================================
   function automatic logic [5:0] count_to_enables(input phase_count_t n);
      logic [5:0] en;
      en = 6'h00;
      for (int i = 0; i < `MAX_PHASES; i++) begin
         if (phase_count_t'(i) < n) begin
            en[i] = 1'b1;
         end
      end
      return en;
   endfunction : count_to_enables

   always_ff @(posedge CLK) begin
      if (RESET) begin
         PHASE_ENABLE <= 6'h3F;
      end else if (CE) begin
         PHASE_ENABLE <= count_to_enables(sif.cur_count);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         DIODE_EMULATION <= 1'b0;
         OFFSET_APPLIED <= 1'b1;
      end else if (CE) begin
         DIODE_EMULATION <= psi_s && power_savings_control_reg[`PS_DIODE_BIT];
         OFFSET_APPLIED <= !(psi_s && power_savings_control_reg[`PS_OFFSET_BIT]);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         GATE_DRIVE_OPTIMISATION_LEVEL <= 2'h0;
         DROOP_GAIN_SEL <= 2'h0;
         NB_DROOP_ENABLE <= 1'b0;
      end else if (CE) begin
         GATE_DRIVE_OPTIMISATION_LEVEL <= phase_count_gate_level_reg[`PG_GATE_LSB +: 2];
         DROOP_GAIN_SEL <= droop_and_psm_phase_override_reg[`DR_GAIN_LSB +: 2];
         if (droop_and_psm_phase_override_reg[`DR_NB_LSB + 1]) begin
            NB_DROOP_ENABLE <= droop_and_psm_phase_override_reg[`DR_NB_LSB];
         end else begin
            NB_DROOP_ENABLE <= strap_nb_s;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         SLEW_RATE_SEL <= 2'h0;
         ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN <= 1'b1;
         ALIGNMENT_MONITOR_COMP <= 1'b0;
      end else if (CE) begin
         SLEW_RATE_SEL <= slew_and_alignment_control_reg[`SA_SLEW_LSB +: 2];
         ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN <= slew_and_alignment_control_reg[`SA_EVT_BIT];
         ALIGNMENT_MONITOR_COMP <= slew_and_alignment_control_reg[`SA_MON_BIT];
      end
   end
endmodule : psm_phase_config_regs

/* File: core/psm_cfg_regs.svh */
// Register offsets, field positions, reset values and counts of the phase config bank.
// Function
// - Power-savings bit 0 enables diode emulation in power savings; resets enabled.
// - Power-savings bits 2:1 space phase additions: one, two, four cycles, or all.
// - Power-savings bits 4:3 space phase drops: one, two, four cycles, or all.
// - Power-savings bit 5 clear keeps offset in power savings; set removes it.
// - Phase, droop and slew registers take writes only while power good is low.
// - Phase register bits 6:2 pick active phase count; resets to six phases.
// - Phase register bits 1:0 pick gate drive level; resets to lowest level.
// - Droop register bits 5:4 override power-savings phase count: pins, one, two.
// - Droop register bits 3:2 scale droop: one, off, half, quarter.
// - Droop register bits 1:0 override northbridge droop: pins, off, on.
// - Slew register bits 7:6 pick the voltage change ramp rate.
// - Slew register bit 5 enables both alignment events; resets enabled.
// - Slew register bit 4 picks alignment monitor: sense input or error amplifier.
// - Power-savings bits 7:6 read zero and change nothing.
`ifndef PSM_CFG_REGS_SVH
`define PSM_CFG_REGS_SVH

`define OFS_POWER_SAVINGS 8'h00
`define OFS_PHASE_GATE 8'h04
`define OFS_DROOP_OVERRIDE 8'h08
`define OFS_SLEW_ALIGN 8'h0C
`define OFS_STATUS 8'h10

`define RST_POWER_SAVINGS 8'h01
`define RST_PHASE_GATE 8'h7C
`define RST_DROOP_OVERRIDE 8'h00
`define RST_SLEW_ALIGN 8'h20

`define MASK_POWER_SAVINGS 8'h3F
`define MASK_PHASE_GATE 8'h7F
`define MASK_DROOP_OVERRIDE 8'h3F
`define MASK_SLEW_ALIGN 8'hF0

`define PS_DIODE_BIT 0
`define PS_ADD_LSB 1
`define PS_DROP_LSB 3
`define PS_OFFSET_BIT 5
`define PG_GATE_LSB 0
`define PG_PHASE_LSB 2
`define DR_NB_LSB 0
`define DR_GAIN_LSB 2
`define DR_PSM_LSB 4
`define SA_MON_BIT 4
`define SA_EVT_BIT 5
`define SA_SLEW_LSB 6

`define MAX_PHASES 6
`define GAP_CYCLES_ONE 3'd1
`define GAP_CYCLES_TWO 3'd2
`define GAP_CYCLES_FOUR 3'd4

`endif

/* File: core/psm_cfg_pkg.sv */
// Types and shared helper functions of the phase config bank.
package psm_cfg_pkg;
   typedef enum logic [1:0] {GAP_ONE, GAP_TWO, GAP_FOUR, GAP_ALL} gap_t;
   typedef enum logic {SEQ_SETTLED, SEQ_STEPPING} seq_state_t;
   typedef logic [2:0] phase_count_t;

   // Returns one more than the leading ones from bit 0; a malformed field counts only its low run.
   function automatic phase_count_t therm_to_count(input logic [4:0] field);
      phase_count_t n;
      n = 3'd1;
      for (int i = 0; i < 5; i++) begin
         if (field[i] && (n == phase_count_t'(i + 1))) begin
            n = phase_count_t'(i + 2);
         end
      end
      return n;
   endfunction : therm_to_count
endpackage : psm_cfg_pkg

/* File: core/seq_if.sv */
// Carrier between the register bank and the phase sequencer.
`timescale 1ns/1ps
interface seq_if;
   import psm_cfg_pkg::*;
   phase_count_t full_count;
   phase_count_t psm_count;
   logic psm_active;
   gap_t add_gap;
   gap_t drop_gap;
   logic pwm_tick;
   phase_count_t cur_count;
   logic stepping;
   modport bank (
      output full_count, psm_count, psm_active, add_gap, drop_gap, pwm_tick,
      input cur_count, stepping
   );
   modport seq (
      input full_count, psm_count, psm_active, add_gap, drop_gap, pwm_tick,
      output cur_count, stepping
   );
endinterface : seq_if

/* File: core/level_sync.sv */
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module level_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic d,
   output logic q
);
   logic meta_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else if (ce) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : level_sync

/* File: core/phase_sequencer.sv */
// Steps the active phase count toward its target, pacing each step in PWM cycles, or jumping straight to it when the gap is GAP_ALL.
`timescale 1ns/1ps
`include "psm_cfg_regs.svh"
module phase_sequencer
   import psm_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   seq_if.seq sif
);
   phase_count_t target;
   phase_count_t count_reg;
   logic [2:0] gap_cnt_reg;
   logic [2:0] gap_len;
   gap_t gap;
   seq_state_t state_reg;

   function automatic logic [2:0] gap_cycles(input gap_t g);
      case (g)
         GAP_TWO: return `GAP_CYCLES_TWO;
         GAP_FOUR: return `GAP_CYCLES_FOUR;
         default: return `GAP_CYCLES_ONE;
      endcase
   endfunction : gap_cycles

   // Power savings never raises the count above the configured full count.
   always_comb begin
      target = sif.full_count;
      if (sif.psm_active && (sif.psm_count < sif.full_count)) begin
         target = sif.psm_count;
      end
      gap = (target < count_reg) ? sif.drop_gap : sif.add_gap;
      gap_len = gap_cycles(gap);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= phase_count_t'(`MAX_PHASES);
         gap_cnt_reg <= 3'h0;
         state_reg <= SEQ_SETTLED;
      end else if (ce) begin
         case (state_reg)
            SEQ_SETTLED: begin
               gap_cnt_reg <= 3'h0;
               if (count_reg != target) begin
                  state_reg <= SEQ_STEPPING;
               end
            end
            SEQ_STEPPING: begin
               if (count_reg == target) begin
                  state_reg <= SEQ_SETTLED;
               end else if (gap == GAP_ALL) begin
                  count_reg <= target;
                  state_reg <= SEQ_SETTLED;
               end else if (sif.pwm_tick) begin
                  if (gap_cnt_reg + 3'd1 >= gap_len) begin
                     gap_cnt_reg <= 3'h0;
                     count_reg <= (target < count_reg) ? count_reg - 3'd1
                                                       : count_reg + 3'd1;
                  end else begin
                     gap_cnt_reg <= gap_cnt_reg + 3'd1;
                  end
               end
            end
            default: state_reg <= SEQ_SETTLED;
         endcase
      end
   end

   assign sif.cur_count = count_reg;
   assign sif.stepping = (state_reg == SEQ_STEPPING);
endmodule : phase_sequencer

/* File: sim/psm_phase_config_regs_properties.sv */
// Port-level checker of the phase config bank.
`timescale 1ns/1ps
`include "psm_cfg_regs.svh"
module psm_phase_config_regs_properties (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   input wire logic [31:0] DAT_O,
   input wire logic ACK_O,
   input wire logic POWER_GOOD_INPUT,
   input wire logic [5:0] PHASE_ENABLE,
   input wire logic DIODE_EMULATION,
   input wire logic OFFSET_APPLIED,
   input wire logic [1:0] GATE_DRIVE_OPTIMISATION_LEVEL,
   input wire logic [1:0] DROOP_GAIN_SEL,
   input wire logic NB_DROOP_ENABLE,
   input wire logic [1:0] SLEW_RATE_SEL,
   input wire logic ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN,
   input wire logic ALIGNMENT_MONITOR_COMP
);
   // =====================================================
   // Helper logic
   // The lock follows the pin two enabled edges late, as the bank's synchroniser does.
   logic [1:0] pg_hist;
   logic wr;
   logic locked;
   assign wr = CE && CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0];
   assign locked = pg_hist[1];
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pg_hist <= 2'h0;
      end else if (CE) begin
         pg_hist <= {pg_hist[0], POWER_GOOD_INPUT};
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   // =====================================================
   // Assertions
   a_diode_off: assert property (wr && ADR_I == `OFS_POWER_SAVINGS && !DAT_I[0] |=>
      ##1 !DIODE_EMULATION) else $error("diode emulation on after clearing it");
   a_offset_kept: assert property (wr && ADR_I == `OFS_POWER_SAVINGS && !DAT_I[5] |=>
      ##1 OFFSET_APPLIED) else $error("offset removed while kept");
   a_gate_level: assert property (wr && ADR_I == `OFS_PHASE_GATE && !locked |=>
      ##1 GATE_DRIVE_OPTIMISATION_LEVEL == $past(DAT_I[1:0], 2)) else $error("gate level");
   a_write_lock: assert property (wr && locked && ADR_I inside {8'h04, 8'h08, 8'h0C} |=>
      ##1 $stable({GATE_DRIVE_OPTIMISATION_LEVEL, DROOP_GAIN_SEL, SLEW_RATE_SEL,
      ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN, ALIGNMENT_MONITOR_COMP}))
      else $error("locked register changed");
   a_droop_gain: assert property (wr && ADR_I == `OFS_DROOP_OVERRIDE && !locked |=>
      ##1 DROOP_GAIN_SEL == $past(DAT_I[3:2], 2)) else $error("droop gain");
   a_nb_override: assert property (wr && ADR_I == `OFS_DROOP_OVERRIDE && !locked
      && DAT_I[1] |=> ##1 NB_DROOP_ENABLE == $past(DAT_I[0], 2)) else $error("nb override");
   a_slew_field: assert property (wr && ADR_I == `OFS_SLEW_ALIGN && !locked |=>
      ##1 SLEW_RATE_SEL == $past(DAT_I[7:6], 2)) else $error("slew rate");
   a_align_bits: assert property (wr && ADR_I == `OFS_SLEW_ALIGN && !locked |=>
      ##1 {ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN, ALIGNMENT_MONITOR_COMP} == $past(DAT_I[5:4], 2))
      else $error("alignment bits");
   a_reserved_zero: assert property (CE && CYC_I && STB_I && !WE_I && !ACK_O
      && ADR_I == `OFS_POWER_SAVINGS |=> ACK_O && DAT_O[31:6] == 26'h0)
      else $error("reserved bits read nonzero");
   a_phase_therm: assert property (PHASE_ENABLE inside
      {6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F}) else $error("phase enable not thermometer");
   c_locked_write: cover property (wr && locked);
   c_one_phase: cover property (PHASE_ENABLE == 6'h01);
   c_diode_on: cover property (DIODE_EMULATION);
endmodule : psm_phase_config_regs_properties

bind psm_phase_config_regs psm_phase_config_regs_properties i_props (.CLK(CLK), .RESET(RESET),
   .CE(CE), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
   .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .POWER_GOOD_INPUT(POWER_GOOD_INPUT),
   .PHASE_ENABLE(PHASE_ENABLE), .DIODE_EMULATION(DIODE_EMULATION),
   .OFFSET_APPLIED(OFFSET_APPLIED), .GATE_DRIVE_OPTIMISATION_LEVEL(GATE_DRIVE_OPTIMISATION_LEVEL),
   .DROOP_GAIN_SEL(DROOP_GAIN_SEL), .NB_DROOP_ENABLE(NB_DROOP_ENABLE),
   .SLEW_RATE_SEL(SLEW_RATE_SEL),
   .ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN(ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN),
   .ALIGNMENT_MONITOR_COMP(ALIGNMENT_MONITOR_COMP));

/* File: sim/psm_phase_config_regs_tb_top.sv */
// Self-checking testbench of the phase config bank.
`timescale 1ns/1ps
module psm_phase_config_regs_tb_top;
   logic CLK, RESET, CE, CYC_I, STB_I, WE_I, ACK_O;
   logic [7:0] ADR_I;
   logic [3:0] SEL_I;
   logic [31:0] DAT_I, DAT_O, rd;
   logic POWER_GOOD_INPUT, POWER_SAVINGS_INDICATOR, PIN_PSM_TWO_PHASES;
   logic PIN_NB_DROOP_ENABLE, PWM_CYCLE_TICK, DIODE_EMULATION, OFFSET_APPLIED;
   logic NB_DROOP_ENABLE, ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN, ALIGNMENT_MONITOR_COMP;
   logic [5:0] PHASE_ENABLE;
   logic [1:0] GATE_DRIVE_OPTIMISATION_LEVEL, DROOP_GAIN_SEL, SLEW_RATE_SEL;
   int miscompares, check_count, cycles, i;
   logic [7:0] rst_vals [0:3] = '{8'h01, 8'h7C, 8'h00, 8'h20};
   // Each row is offset, written byte, expected read-back byte.
   logic [23:0] rows [0:19] = '{24'h00_00_00, 24'h00_0A_0A, 24'h00_14_14, 24'h00_1E_1E,
      24'h00_FF_3F, 24'h04_7C_7C, 24'h04_7D_7D, 24'h04_7E_7E, 24'h04_FF_7F, 24'h04_83_03,
      24'h08_00_00, 24'h08_15_15, 24'h08_2A_2A, 24'h08_FF_3F, 24'h0C_00_00, 24'h0C_50_50,
      24'h0C_A0_A0, 24'h0C_FF_F0, 24'h14_FF_00, 24'h80_5A_00};

   psm_phase_config_regs i_psm_phase_config_regs (.CLK(CLK), .RESET(RESET), .CE(CE),
      .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
      .DAT_O(DAT_O), .ACK_O(ACK_O), .POWER_GOOD_INPUT(POWER_GOOD_INPUT),
      .POWER_SAVINGS_INDICATOR(POWER_SAVINGS_INDICATOR), .PIN_PSM_TWO_PHASES(PIN_PSM_TWO_PHASES),
      .PIN_NB_DROOP_ENABLE(PIN_NB_DROOP_ENABLE), .PWM_CYCLE_TICK(PWM_CYCLE_TICK),
      .PHASE_ENABLE(PHASE_ENABLE), .DIODE_EMULATION(DIODE_EMULATION),
      .OFFSET_APPLIED(OFFSET_APPLIED), .GATE_DRIVE_OPTIMISATION_LEVEL(GATE_DRIVE_OPTIMISATION_LEVEL),
      .DROOP_GAIN_SEL(DROOP_GAIN_SEL), .NB_DROOP_ENABLE(NB_DROOP_ENABLE),
      .SLEW_RATE_SEL(SLEW_RATE_SEL),
      .ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN(ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN),
      .ALIGNMENT_MONITOR_COMP(ALIGNMENT_MONITOR_COMP));

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // =====================================================
   // Shared tasks
   task test_done;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // The request is held until ack is seen at an edge; no ack within 19 clocks counts as a miscompare.
   task wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge CLK);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= we;
      ADR_I <= a;
      DAT_I <= {24'h0, d};
      SEL_I <= s;
      do begin
         @(posedge CLK);
         n++;
      end while (ACK_O !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         $display("FAIL %0t no ack", $time);
      end
      rd = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      WE_I <= 1'b0;
   endtask : wb

   task ticks(input int n);
      repeat (n) begin
         @(posedge CLK);
         PWM_CYCLE_TICK <= 1'b1;
         @(posedge CLK);
         PWM_CYCLE_TICK <= 1'b0;
         repeat (2) @(posedge CLK);
      end
   endtask : ticks

   always @(posedge CLK) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         $display("FAIL %0t timeout", $time);
         test_done();
      end
   end

   // =====================================================
   // Main sequence
   initial begin
      {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = '0;
      {POWER_GOOD_INPUT, POWER_SAVINGS_INDICATOR, PWM_CYCLE_TICK} = 3'h0;
      PIN_PSM_TWO_PHASES = 1'b1;
      PIN_NB_DROOP_ENABLE = 1'b1;
      CE = 1'b1;
      RESET = 1'b1;
      miscompares = 0;
      check_count = 0;
      cycles = 0;
      repeat (12) @(posedge CLK);
      RESET <= 1'b0;
      for (i = 0; i < 20; i++) begin
         wb(1'b1, rows[i][23:16], rows[i][15:8], 4'hF);
         wb(1'b0, rows[i][23:16], 8'h00, 4'hF);
         check(rd, {24'h0, rows[i][7:0]}, "readback");
      end
      // A second reset in mid-run must restore every register and every control output except NB_DROOP_ENABLE.
      @(posedge CLK);
      RESET <= 1'b1;
      repeat (12) @(posedge CLK);
      RESET <= 1'b0;
      repeat (3) @(posedge CLK);
      check({24'h0, PHASE_ENABLE, DIODE_EMULATION, OFFSET_APPLIED}, 32'h0000_00FD, "rst");
      check({22'h0, GATE_DRIVE_OPTIMISATION_LEVEL, DROOP_GAIN_SEL, SLEW_RATE_SEL,
         ADAPTIVE_PHASE_ALIGNMENT_EVENTS_EN, ALIGNMENT_MONITOR_COMP, 2'h0}, 32'h8, "rst");
      for (i = 0; i < 4; i++) begin
         wb(1'b0, 8'(i * 4), 8'h00, 4'hF);
         check(rd, {24'h0, rst_vals[i]}, "reset value");
      end
      // With power good high only the power-savings register still takes writes.
      POWER_GOOD_INPUT <= 1'b1;
      repeat (4) @(posedge CLK);
      for (i = 0; i < 4; i++) begin
         wb(1'b1, 8'(i * 4), 8'h0A, 4'hF);
         wb(1'b0, 8'(i * 4), 8'h00, 4'hF);
         check(rd, {24'h0, (i == 0) ? 8'h0A : rst_vals[i]}, "locked write");
      end
      wb(1'b1, 8'h00, 8'h21, 4'hE);
      wb(1'b0, 8'h00, 8'h00, 4'hF);
      check(rd, 32'h0A, "byte lane off");
      POWER_GOOD_INPUT <= 1'b0;
      repeat (4) @(posedge CLK);
      // With the clock enable low the bank must not even answer the bus.
      CE <= 1'b0;
      fork
         wb(1'b1, 8'h00, 8'h0B, 4'hF);
         begin
            repeat (4) @(posedge CLK);
            check({31'h0, ACK_O}, 32'h0, "ack while frozen");
            CE <= 1'b1;
         end
      join
      wb(1'b0, 8'h00, 8'h00, 4'hF);
      check(rd, 32'h0B, "write after freeze");
      // Force one phase, drop every four ticks, then add all phases back at once.
      wb(1'b1, 8'h08, 8'h20, 4'hF);
      wb(1'b1, 8'h00, 8'h31, 4'hF);
      POWER_SAVINGS_INDICATOR <= 1'b1;
      repeat (6) @(posedge CLK);
      ticks(3);
      check({26'h0, PHASE_ENABLE}, 32'h3F, "drop early");
      ticks(1);
      check({26'h0, PHASE_ENABLE}, 32'h1F, "first drop");
      ticks(16);
      check({24'h0, PHASE_ENABLE, DIODE_EMULATION, OFFSET_APPLIED}, 32'h06, "psm");
      wb(1'b1, 8'h00, 8'h37, 4'hF);
      POWER_SAVINGS_INDICATOR <= 1'b0;
      repeat (8) @(posedge CLK);
      check({24'h0, PHASE_ENABLE, DIODE_EMULATION, OFFSET_APPLIED}, 32'hFD, "leave");
      test_done();
   end
endmodule : psm_phase_config_regs_tb_top
